// >>> pkg/mrb_pkg.sv
// constants and carrier types for the mode-register bank at 15h..19h
package mrb_pkg;
  localparam logic [5:0] ADDR_VENDOR = 6'h15;
  localparam logic [5:0] ADDR_TERM   = 6'h16;
  localparam logic [5:0] ADDR_OSC    = 6'h17;
  localparam logic [5:0] ADDR_ACT    = 6'h18;
  localparam logic [5:0] ADDR_REPAIR = 6'h19;

  // termination_control field positions
  localparam int CTRL_TERM_LSB     = 0;
  localparam int CTRL_TERM_MSB     = 2;
  localparam int TERM_CLK_BIT      = 3;
  localparam int TERM_CS_BIT       = 4;
  localparam int TERM_CA_DIS_BIT   = 5;
  localparam int TERM_LOW_SEL_BIT  = 6;
  localparam int TERM_HIGH_SEL_BIT = 7;
  localparam logic [2:0] CTRL_TERM_OFF  = 3'h0;
  localparam logic [2:0] CTRL_TERM_RSVD = 3'h7;
  localparam logic [2:0] BUS_TERM_OFF   = 3'h0;

  // row_refresh_activate_limit field positions
  localparam int ACT_ENABLE_BIT    = 7;
  localparam int ACT_BANK_LSB      = 4;
  localparam int ACT_UNLIMITED_BIT = 3;

  localparam logic [7:0] TERM_RESET   = 8'h00;
  localparam logic [7:0] OSC_RESET    = 8'h00;
  localparam logic [3:0] ACT_RESET    = 4'h0;
  localparam logic [7:0] READ_ZERO    = 8'h00;
  // arbitrary value returned by the vendor-private register
  localparam logic [7:0] VENDOR_VALUE = 8'h00;

  // multipurpose command operands for the interval oscillator
  localparam logic [6:0] MPC_OSC_STOP  = 7'h4d;
  localparam logic [6:0] MPC_OSC_START = 7'h4b;

  // oscillator run-time decode, counted in channel clocks
  localparam logic [1:0]  OSC_MODE_N    = 2'h0;
  localparam logic [1:0]  OSC_MODE_2K   = 2'h1;
  localparam logic [1:0]  OSC_MODE_4K   = 2'h2;
  localparam logic [12:0] OSC_STEP      = 13'h0010;
  localparam logic [12:0] OSC_LIM_2K    = 13'h0800;
  localparam logic [12:0] OSC_LIM_4K    = 13'h1000;
  localparam logic [12:0] OSC_LIM_NONE  = 13'h0000;

  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic       is_mpc;
    logic [5:0] addr;
    logic [7:0] data;
  } mrb_cmd_t;

  typedef struct packed {
    logic       clk;
    logic       cs;
    logic       ca;
    logic [2:0] ctrl;
  } mrb_term_t;

  typedef enum logic {MRB_OSC_IDLE, MRB_OSC_RUN} mrb_osc_state_t;
endpackage

// >>> logic/mrb_sync.sv
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module mrb_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// >>> logic/mrb_osc.sv
// interval oscillator run timer with automatic or commanded stop
`timescale 1ns/1ps
module mrb_osc (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ck_rise,
  input  wire logic       start,
  input  wire logic       stop_cmd,
  input  wire logic [7:0] run_time,
  output logic            running
);
  mrb_pkg::mrb_osc_state_t state_ff;
  logic [12:0]             cnt_ff;
  logic [12:0]             lim_ff;
  logic [12:0]             cnt_inc;

  function automatic logic [12:0] osc_limit(input logic [7:0] rt);
    logic [12:0] lim;
    lim = mrb_pkg::OSC_LIM_NONE;
    case (rt[7:6])
      mrb_pkg::OSC_MODE_N:  lim = 13'({7'h00, rt[5:0]} * mrb_pkg::OSC_STEP);
      mrb_pkg::OSC_MODE_2K: lim = mrb_pkg::OSC_LIM_2K;
      mrb_pkg::OSC_MODE_4K: lim = mrb_pkg::OSC_LIM_4K;
      default:              lim = mrb_pkg::OSC_LIM_NONE;
    endcase
    return lim;
  endfunction

  assign cnt_inc = cnt_ff + 13'h0001;
  assign running = (state_ff == mrb_pkg::MRB_OSC_RUN);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= mrb_pkg::MRB_OSC_IDLE;
      cnt_ff   <= 13'h0000;
      lim_ff   <= mrb_pkg::OSC_LIM_NONE;
    end else if (start) begin
      state_ff <= mrb_pkg::MRB_OSC_RUN;
      cnt_ff   <= 13'h0000;
      lim_ff   <= osc_limit(run_time);
    end else begin
      case (state_ff)
        mrb_pkg::MRB_OSC_RUN: begin
          if (stop_cmd) begin
            state_ff <= mrb_pkg::MRB_OSC_IDLE;
          end else if (ck_rise) begin
            cnt_ff <= cnt_inc;
            if (lim_ff != mrb_pkg::OSC_LIM_NONE && cnt_inc == lim_ff) begin
              state_ff <= mrb_pkg::MRB_OSC_IDLE;
            end
          end
        end
        default: state_ff <= mrb_pkg::MRB_OSC_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_osc_auto_stop: assert property ($fell(running) && !$past(stop_cmd) && !$past(start)
    |-> $past(lim_ff) != mrb_pkg::OSC_LIM_NONE && $past(cnt_inc) == $past(lim_ff))
    else $error("oscillator stopped before its run time");
  a_osc_no_early: assert property (running && ck_rise && !stop_cmd && !start
    && lim_ff != mrb_pkg::OSC_LIM_NONE && cnt_inc != lim_ff |=> running)
    else $error("oscillator stopped off its limit");
  a_osc_cmd_stop: assert property (running && stop_cmd && !start |=> !running)
    else $error("stop command ignored");
  c_osc_auto: cover property ($fell(running) && $past(lim_ff) == mrb_pkg::OSC_LIM_2K);
endmodule

// >>> logic/mrb_regs.sv
// mode-register bank: termination, oscillator run time, refresh mode, repair report
`timescale 1ns/1ps
// Functional notes
// - address 15h is vendor private; writes ignored, reads give a fixed value.
// - termination bits 2:0 pick controller termination; 000 off, 111 reserved.
// - clock termination override bit 3 terminates clocks regardless of pad.
// - chip-select override bit 4 terminates chip select regardless of pad.
// - bit 5 clear: CA terminates on pad high and valid value; set: never.
// - one copy per set point; writes and reads use the write set point.
// - operation uses the operating set point copy only; other copy ignored.
// - terminating rank keeps terminating in every power state.
// - run time zero manual; 00 N stops after N*16; 01/10 after 2048/4096.
// - with run time zero the stop command halts the oscillator.
// - activate limit code reports 700K..200K; 000 untested when bit 3 clear.
// - unlimited flag set means no activate limit and code reads zero.
// - bit 7 enables target-row-refresh mode; resets disabled.
// - address 19h reads one repair flag per bank, one means available.
module mrb_regs (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ck_link,
  input  wire mrb_pkg::mrb_cmd_t cmd_pins,
  input  wire logic              bus_term_pad,
  input  wire logic [2:0]        bus_term_value_reg,
  input  wire logic              write_setpoint_select,
  input  wire logic              operating_setpoint_select,
  input  wire logic [2:0]        max_activate_code,
  input  wire logic              unlimited_activate_flag,
  input  wire logic [7:0]        repair_resource_flag,
  output mrb_pkg::mrb_term_t     term_state,
  output logic                   row_refresh_enable,
  output logic [2:0]             row_refresh_target_bank,
  output logic                   osc_running,
  output logic                   rd_valid,
  output logic [7:0]             rd_data
);
  localparam int CW = $bits(mrb_pkg::mrb_cmd_t);

  logic [CW+1:0]      sync_q;
  mrb_pkg::mrb_cmd_t  cmd_s;
  logic               ck_s;
  logic               pad_s;
  logic               ck_prev_ff;
  logic               ck_rise;
  logic               take;
  logic               wr;
  logic               rd;
  logic               mpc;
  logic [7:0]         term_copy_ff [2];
  logic [7:0]         op_copy;
  logic [7:0]         wr_copy;
  logic               bus_valid;
  mrb_pkg::mrb_term_t nxt_term;
  mrb_pkg::mrb_term_t term_ff;
  logic [7:0]         osc_run_ff;
  logic [3:0]         act_ctl_ff;
  logic [7:0]         act_read;
  logic               rd_valid_ff;
  logic [7:0]         rd_data_ff;
  logic [5:0]         rd_addr_ff;
  logic               osc_start;
  logic               osc_stop;

  function automatic logic in_map(input logic [5:0] a);
    return a >= mrb_pkg::ADDR_VENDOR && a <= mrb_pkg::ADDR_REPAIR;
  endfunction

  mrb_sync #(.W(CW + 2)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({ck_link, bus_term_pad, cmd_pins}),
    .q       (sync_q)
  );

  assign ck_s  = sync_q[CW+1];
  assign pad_s = sync_q[CW];
  assign cmd_s = sync_q[CW-1:0];

  // commands are taken on the channel clock rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ck_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= ck_s;
    end
  end

  assign ck_rise = ck_s & ~ck_prev_ff;
  assign take    = ck_rise & cmd_s.valid;
  assign wr      = take & cmd_s.is_write & ~cmd_s.is_mpc;
  assign rd      = take & ~cmd_s.is_write & ~cmd_s.is_mpc;
  assign mpc     = take & cmd_s.is_mpc;

  // termination copies, one per set point
  for (genvar g = 0; g < 2; g++) begin : g_copy
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        term_copy_ff[g] <= mrb_pkg::TERM_RESET;
      // write lands in write set point copy
      end else if (wr && cmd_s.addr == mrb_pkg::ADDR_TERM
                   && write_setpoint_select == 1'(g)) begin
        term_copy_ff[g] <= cmd_s.data;
      end
    end
  end

  assign op_copy   = term_copy_ff[operating_setpoint_select];
  assign wr_copy   = term_copy_ff[write_setpoint_select];
  assign bus_valid = bus_term_value_reg != mrb_pkg::BUS_TERM_OFF;

  always_comb begin
    nxt_term.clk = bus_valid & (op_copy[mrb_pkg::TERM_CLK_BIT] | pad_s);
    nxt_term.cs  = bus_valid & (op_copy[mrb_pkg::TERM_CS_BIT] | pad_s);
    nxt_term.ca  = ~op_copy[mrb_pkg::TERM_CA_DIS_BIT] & pad_s & bus_valid;
    // reserved controller code acts as off
    if (op_copy[mrb_pkg::CTRL_TERM_MSB:mrb_pkg::CTRL_TERM_LSB] == mrb_pkg::CTRL_TERM_RSVD) begin
      nxt_term.ctrl = mrb_pkg::CTRL_TERM_OFF;
    end else begin
      nxt_term.ctrl = op_copy[mrb_pkg::CTRL_TERM_MSB:mrb_pkg::CTRL_TERM_LSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      term_ff <= '0;
    end else begin
      term_ff <= nxt_term;
    end
  end

  assign term_state = term_ff;

  // oscillator run time setting
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_run_ff <= mrb_pkg::OSC_RESET;
    end else if (wr && cmd_s.addr == mrb_pkg::ADDR_OSC) begin
      osc_run_ff <= cmd_s.data;
    end
  end

  assign osc_start = mpc && cmd_s.data[6:0] == mrb_pkg::MPC_OSC_START;
  // stop with nonzero run time is dropped
  assign osc_stop  = mpc && cmd_s.data[6:0] == mrb_pkg::MPC_OSC_STOP
                     && osc_run_ff == mrb_pkg::OSC_RESET;

  mrb_osc u_osc (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .ck_rise  (ck_rise),
    .start    (osc_start),
    .stop_cmd (osc_stop),
    .run_time (osc_run_ff),
    .running  (osc_running)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      act_ctl_ff <= mrb_pkg::ACT_RESET;
    end else if (wr && cmd_s.addr == mrb_pkg::ADDR_ACT) begin
      act_ctl_ff <= cmd_s.data[mrb_pkg::ACT_ENABLE_BIT:mrb_pkg::ACT_BANK_LSB];
    end
  end

  assign row_refresh_enable      = act_ctl_ff[3];
  assign row_refresh_target_bank = act_ctl_ff[2:0];

  // limit code reported; zero when unlimited
  assign act_read = {act_ctl_ff, unlimited_activate_flag,
                     unlimited_activate_flag ? 3'h0 : max_activate_code};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= mrb_pkg::READ_ZERO;
      rd_addr_ff  <= 6'h00;
    end else begin
      rd_valid_ff <= rd && in_map(cmd_s.addr);
      if (rd) begin
        rd_addr_ff <= cmd_s.addr;
        case (cmd_s.addr)
          mrb_pkg::ADDR_VENDOR: rd_data_ff <= mrb_pkg::VENDOR_VALUE;
          // read from write set point copy
          mrb_pkg::ADDR_TERM:   rd_data_ff <= wr_copy;
          mrb_pkg::ADDR_OSC:    rd_data_ff <= mrb_pkg::READ_ZERO;
          mrb_pkg::ADDR_ACT:    rd_data_ff <= act_read;
          mrb_pkg::ADDR_REPAIR: rd_data_ff <= repair_resource_flag;
          default:              rd_data_ff <= mrb_pkg::READ_ZERO;
        endcase
      end
    end
  end

  assign rd_valid = rd_valid_ff;
  assign rd_data  = rd_data_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_copy_inactive_kept: assert property (wr && cmd_s.addr == mrb_pkg::ADDR_TERM
    |=> term_copy_ff[!$past(write_setpoint_select)]
        == $past(term_copy_ff[!write_setpoint_select]))
    else $error("inactive set point copy changed on write");
  a_clk_override: assert property (op_copy[mrb_pkg::TERM_CLK_BIT] && bus_valid
    |=> term_state.clk)
    else $error("clock termination override not applied");
  a_cs_override: assert property (op_copy[mrb_pkg::TERM_CS_BIT] && bus_valid
    |=> term_state.cs)
    else $error("chip-select termination override not applied");
  a_ca_term_cause: assert property (term_state.ca
    |-> $past(pad_s) && $past(bus_valid) && !$past(op_copy[mrb_pkg::TERM_CA_DIS_BIT]))
    else $error("CA terminated without pad, value or with disable");
  a_ctrl_term_value: assert property (term_state.ctrl != mrb_pkg::CTRL_TERM_OFF
    |-> term_state.ctrl == $past(op_copy[2:0])
        && term_state.ctrl != mrb_pkg::CTRL_TERM_RSVD)
    else $error("controller termination code mismatch");
  a_op_copy_only: assert property ($stable(term_copy_ff[operating_setpoint_select])
    && $stable(operating_setpoint_select) && $stable(pad_s) && $stable(bus_term_value_reg)
    |=> $stable(term_state))
    else $error("termination moved without operating copy change");
  a_unlimited_zero: assert property (rd_valid && rd_addr_ff == mrb_pkg::ADDR_ACT
    && rd_data[mrb_pkg::ACT_UNLIMITED_BIT] |-> rd_data[2:0] == 3'h0)
    else $error("limit code nonzero while unlimited");
  a_limit_report: assert property (rd && cmd_s.addr == mrb_pkg::ADDR_ACT
    && !unlimited_activate_flag |=> rd_valid && rd_data[2:0] == $past(max_activate_code))
    else $error("activate limit code misreported");
  a_repair_read: assert property (rd && cmd_s.addr == mrb_pkg::ADDR_REPAIR
    |=> rd_valid && rd_data == $past(repair_resource_flag))
    else $error("repair flags misreported");
  a_vendor_read: assert property (rd_valid && rd_addr_ff == mrb_pkg::ADDR_VENDOR
    |-> rd_data == mrb_pkg::VENDOR_VALUE)
    else $error("vendor register value wrong");
  a_refresh_enable: assert property (wr && cmd_s.addr == mrb_pkg::ADDR_ACT
    |=> row_refresh_enable == $past(cmd_s.data[7]) ##1 $stable(row_refresh_enable)[*2])
    else $error("refresh enable not taken from write");
  a_refresh_reset: assert property (disable iff (1'b0) !rst_n |=> !row_refresh_enable)
    else $error("refresh mode not disabled by reset");
  a_stop_filtered: assert property (osc_stop |-> osc_run_ff == mrb_pkg::OSC_RESET)
    else $error("stop passed with nonzero run time");

  c_term_write: cover property (wr && cmd_s.addr == mrb_pkg::ADDR_TERM);
  c_refresh_on: cover property ($rose(row_refresh_enable));
  c_repair_read: cover property (rd_valid && rd_addr_ff == mrb_pkg::ADDR_REPAIR);
endmodule

// >>> bench/mrb_ctrl_model.sv
// controller model issuing mode-register and multipurpose commands on the channel clock
`timescale 1ns/1ps
module mrb_ctrl_model (
  output logic              ck_link,
  output mrb_pkg::mrb_cmd_t cmd_pins
);
  logic [7:0] run_shadow;

  initial begin
    ck_link = 1'b0;
    cmd_pins = '0;
    run_shadow = 8'h00;
  end

  // channel clock only moves inside a frame; released pins show the inverse with valid low
  task automatic frame(input mrb_pkg::mrb_cmd_t c);
    cmd_pins = c;
    #16;
    ck_link = 1'b1;
    #32;
    ck_link = 1'b0;
    #16;
    cmd_pins = {1'b0, ~c[15:0]};
  endtask

  task automatic write(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == mrb_pkg::ADDR_TERM) ? (d & 8'h3f) : d;
    if (a == mrb_pkg::ADDR_OSC)
      run_shadow = v;
    frame({1'b1, 1'b1, 1'b0, a, v});
  endtask

  task automatic read(input logic [5:0] a);
    frame({1'b1, 1'b0, 1'b0, a, 8'h5a});
  endtask

  // stop withheld while run time set, unless bad is given
  task automatic mpc(input logic [6:0] op, input logic bad);
    if (op != mrb_pkg::MPC_OSC_STOP || run_shadow == 8'h00 || bad)
      frame({1'b1, 1'b0, 1'b1, 6'h00, 1'b0, op});
  endtask

  // idle clocks with changing, unqualified pins
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++)
      frame({1'b0, 16'(i)});
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the mode-register bank
`timescale 1ns/1ps
module testbench;
  logic               sys_clk;
  logic               rst_n;
  logic               ck_link;
  mrb_pkg::mrb_cmd_t  cmd_pins;
  logic               bus_term_pad;
  logic [2:0]         bus_term_value_reg;
  logic               write_setpoint_select;
  logic               operating_setpoint_select;
  logic [2:0]         max_activate_code;
  logic               unlimited_activate_flag;
  logic [7:0]         repair_resource_flag;
  mrb_pkg::mrb_term_t term_state;
  logic               row_refresh_enable;
  logic [2:0]         row_refresh_target_bank;
  logic               osc_running;
  logic               rd_valid;
  logic [7:0]         rd_data;
  int                 fail_count;
  int                 checked;
  int                 rd_cnt = 0;
  logic [7:0]         rd_seen = 8'h00;
  logic [7:0]         runs [3] = '{8'h01, 8'h45, 8'h80};
  int                 lims [3] = '{16, 2048, 4096};

  mrb_regs i_mrb_regs (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .ck_link                   (ck_link),
    .cmd_pins                  (cmd_pins),
    .bus_term_pad              (bus_term_pad),
    .bus_term_value_reg        (bus_term_value_reg),
    .write_setpoint_select     (write_setpoint_select),
    .operating_setpoint_select (operating_setpoint_select),
    .max_activate_code         (max_activate_code),
    .unlimited_activate_flag   (unlimited_activate_flag),
    .repair_resource_flag      (repair_resource_flag),
    .term_state                (term_state),
    .row_refresh_enable        (row_refresh_enable),
    .row_refresh_target_bank   (row_refresh_target_bank),
    .osc_running               (osc_running),
    .rd_valid                  (rd_valid),
    .rd_data                   (rd_data)
  );

  mrb_ctrl_model i_mrb_ctrl_model (
    .ck_link  (ck_link),
    .cmd_pins (cmd_pins)
  );

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  // read answers are one-cycle pulses, so capture them here
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_seen <= rd_data;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_mrb_ctrl_model.write(a, d);
    settle;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    int n0;
    n0 = rd_cnt;
    i_mrb_ctrl_model.read(a);
    settle;
    check(8'(rd_cnt - n0), 8'h01);
    check(rd_seen, exp);
  endtask

  task automatic tcheck(input logic [5:0] exp);
    check({2'h0, term_state}, {2'h0, exp});
  endtask

  task automatic ocheck(input logic e);
    check({7'h00, osc_running}, {7'h00, e});
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #480_000;
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict;
  end

  initial begin
    int n0;
    fail_count = 0;
    checked = 0;
    rst_n = 1'b0;
    bus_term_pad = 1'b0;
    bus_term_value_reg = 3'h2;
    write_setpoint_select = 1'b0;
    operating_setpoint_select = 1'b0;
    max_activate_code = 3'h0;
    unlimited_activate_flag = 1'b0;
    repair_resource_flag = 8'ha5;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    settle;
    tcheck(6'h00);
    check({4'h0, row_refresh_enable, row_refresh_target_bank}, 8'h00);
    rd(mrb_pkg::ADDR_TERM, mrb_pkg::TERM_RESET);
    rd(mrb_pkg::ADDR_VENDOR, mrb_pkg::VENDOR_VALUE);
    wr(mrb_pkg::ADDR_VENDOR, 8'hff);
    rd(mrb_pkg::ADDR_VENDOR, mrb_pkg::VENDOR_VALUE);
    wr(mrb_pkg::ADDR_REPAIR, 8'h00);
    rd(mrb_pkg::ADDR_REPAIR, 8'ha5);
    repair_resource_flag = 8'h3c;
    rd(mrb_pkg::ADDR_REPAIR, 8'h3c);
    n0 = rd_cnt;
    i_mrb_ctrl_model.read(6'h1a);
    settle;
    check(8'(rd_cnt - n0), 8'h00);
    $display("test access done");

    wr(mrb_pkg::ADDR_TERM, 8'h08);
    tcheck(6'h20);
    wr(mrb_pkg::ADDR_TERM, 8'h13);
    tcheck(6'h13);
    bus_term_pad = 1'b1;
    wr(mrb_pkg::ADDR_TERM, 8'h06);
    tcheck(6'h3e);
    wr(mrb_pkg::ADDR_TERM, 8'h27);
    tcheck(6'h30);
    bus_term_value_reg = 3'h0;
    settle;
    tcheck(6'h00);
    bus_term_value_reg = 3'h2;
    bus_term_pad = 1'b0;
    wr(mrb_pkg::ADDR_TERM, 8'h01);
    write_setpoint_select = 1'b1;
    wr(mrb_pkg::ADDR_TERM, 8'h15);
    tcheck(6'h01);
    rd(mrb_pkg::ADDR_TERM, 8'h15);
    write_setpoint_select = 1'b0;
    rd(mrb_pkg::ADDR_TERM, 8'h01);
    operating_setpoint_select = 1'b1;
    settle;
    tcheck(6'h15);
    wr(mrb_pkg::ADDR_TERM, 8'h08);
    tcheck(6'h15);
    $display("test termination done");

    wr(mrb_pkg::ADDR_ACT, 8'ha0);
    check({4'h0, row_refresh_enable, row_refresh_target_bank}, 8'h0a);
    wr(mrb_pkg::ADDR_ACT, 8'hf0);
    check({4'h0, row_refresh_enable, row_refresh_target_bank}, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      max_activate_code = 3'(c);
      rd(mrb_pkg::ADDR_ACT, {4'hf, 1'b0, 3'(c)});
    end
    max_activate_code = 3'h5;
    unlimited_activate_flag = 1'b1;
    rd(mrb_pkg::ADDR_ACT, 8'hf8);
    // reset in mid-run must drop refresh mode back to disabled
    rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    settle;
    check({4'h0, row_refresh_enable, row_refresh_target_bank}, 8'h00);
    rd(mrb_pkg::ADDR_ACT, 8'h08);
    wr(mrb_pkg::ADDR_ACT, 8'h00);
    check({4'h0, row_refresh_enable, row_refresh_target_bank}, 8'h00);
    $display("test activate done");

    wr(mrb_pkg::ADDR_OSC, 8'h00);
    i_mrb_ctrl_model.mpc(mrb_pkg::MPC_OSC_START, 1'b0);
    i_mrb_ctrl_model.clocks(40);
    settle;
    ocheck(1'b1);
    i_mrb_ctrl_model.mpc(mrb_pkg::MPC_OSC_STOP, 1'b0);
    settle;
    ocheck(1'b0);
    for (int k = 0; k < 3; k++) begin
      wr(mrb_pkg::ADDR_OSC, runs[k]);
      i_mrb_ctrl_model.mpc(mrb_pkg::MPC_OSC_START, 1'b0);
      // stop sent anyway while the run time is set
      i_mrb_ctrl_model.mpc(mrb_pkg::MPC_OSC_STOP, 1'b1);
      i_mrb_ctrl_model.clocks(lims[k] - 6);
      settle;
      ocheck(1'b1);
      i_mrb_ctrl_model.clocks(12);
      settle;
      ocheck(1'b0);
    end
    $display("test oscillator done");
    give_verdict;
  end
endmodule
